// *** rtl/amc_consts.vh ***
// constants for the amplifier mute control block
`ifndef AMC_CONSTS_VH
`define AMC_CONSTS_VH
// register byte offsets
`define AMC_REG_CTRL 4'h0
`define AMC_REG_STAT 4'h4
// control register field positions
`define AMC_CTRL_SWMUTE 0
`define AMC_CTRL_POLHIGH 1
`define AMC_CTRL_PULLUP 2
// control reset value: pull-down, active high, software mute off
`define AMC_CTRL_RST 3'h2
// status register field positions
`define AMC_STAT_MUTE 0
`define AMC_STAT_LINE 1
`define AMC_STAT_PINOPT 4
// interface option codes
`define AMC_OPT_STANDARD 2'h0
`define AMC_OPT_WEB 2'h1
`define AMC_OPT_SERIAL 2'h2
`endif

// *** rtl/amc_mute_ctrl.v ***
// amplifier mute decision with avalon-mm control registers
`timescale 1ns/10ps
//
// Contract
// - mute state turns off output power stage
// - polarity setting selects active high or low
// - bias setting; floating line reads bias level
// - muted when line level equals active level
// - default pull-down bias, high level mutes
// - host writes polarity and bias at run time
// - software mute overrides hardware mute line
// - shared pins assigned by ordered interface option
// - interface option is build-time parameter only
//
`include "amc_consts.vh"

module amc_mute_ctrl #(
	parameter [1:0] PIN_OPTION = `AMC_OPT_STANDARD
) (
	// clock, reset, enable
	input wire clk_sys,
	input wire nrst,
	input wire clkEn,
	// avalon-mm slave
	input wire [3:0] avsAddress,
	input wire avsRead,
	input wire avsWrite,
	input wire [31:0] avsWriteData,
	input wire [3:0] avsByteEnable,
	output reg [31:0] avsReadData,
	output reg avsWaitRequest,
	// mute line pin
	input wire muteLineIn,
	input wire muteLineDriven,
	output reg muteBiasPullUp,
	// amplifier
	output reg powerStageOn,
	output reg muteActive,
	// shared connector pins in standard option
	input wire unitAddrPinIn0,
	input wire unitAddrPinIn1,
	input wire unitAddrPinIn2,
	output reg [2:0] unitAddr,
	output reg ethSelect,
	output reg serialSelect
);

	// ********************************
	// bus handshake
	// ********************************
	// start: request seen while waitrequest high
	// finish: request seen while waitrequest low
	wire busRequest;
	wire busStart;
	wire busFinish;
	wire ctrlSelect;
	wire statSelect;
	assign busRequest = avsRead | avsWrite;
	assign busStart = busRequest & avsWaitRequest;
	assign busFinish = busRequest & ~avsWaitRequest;
	assign ctrlSelect = (avsAddress == `AMC_REG_CTRL);
	assign statSelect = (avsAddress == `AMC_REG_STAT);

	// ********************************
	// control register
	// ********************************
	reg [2:0] ctrl;
	reg [2:0] next_ctrl;

	// write lands at the finishing edge only
	always @* begin
		next_ctrl = ctrl;
		if (avsWrite && busFinish && ctrlSelect && avsByteEnable[0]) begin
			next_ctrl = avsWriteData[2:0];
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl <= `AMC_CTRL_RST;
		end else if (clkEn) begin
			ctrl <= next_ctrl;
		end
	end

	// ********************************
	// mute line synchroniser
	// ********************************
	reg lineSync1;
	reg lineSync2;
	reg drivenSync1;
	reg drivenSync2;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lineSync1 <= 1'b0;
			lineSync2 <= 1'b0;
		end else if (clkEn) begin
			lineSync1 <= muteLineIn;
			lineSync2 <= lineSync1;
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			drivenSync1 <= 1'b0;
			drivenSync2 <= 1'b0;
		end else if (clkEn) begin
			drivenSync1 <= muteLineDriven;
			drivenSync2 <= drivenSync1;
		end
	end

	// ********************************
	// address strap synchroniser
	// ********************************
	// straps idle high, so reset to all ones
	reg [2:0] addrSync1;
	reg [2:0] addrSync2;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			addrSync1 <= 3'h7;
			addrSync2 <= 3'h7;
		end else if (clkEn) begin
			addrSync1 <= {unitAddrPinIn2, unitAddrPinIn1, unitAddrPinIn0};
			addrSync2 <= addrSync1;
		end
	end

	// ********************************
	// mute decision
	// ********************************
	wire biasUp;
	wire lineLevel;
	wire activeLevel;
	wire hwMute;
	wire swMute;
	wire next_mute;
	assign biasUp = ctrl[`AMC_CTRL_PULLUP];
	// floating line reads the selected bias
	assign lineLevel = drivenSync2 ? lineSync2 : biasUp;
	assign activeLevel = ctrl[`AMC_CTRL_POLHIGH];
	assign hwMute = (lineLevel == activeLevel);
	assign swMute = ctrl[`AMC_CTRL_SWMUTE];
	// software mute wins over the line
	assign next_mute = swMute | hwMute;

	// ********************************
	// interface option decode
	// ********************************
	wire optStandard;
	wire optWeb;
	wire optSerial;
	assign optStandard = (PIN_OPTION == `AMC_OPT_STANDARD);
	assign optWeb = (PIN_OPTION == `AMC_OPT_WEB);
	assign optSerial = (PIN_OPTION == `AMC_OPT_SERIAL);

	reg [2:0] next_unitAddr;
	always @* begin
		next_unitAddr = 3'h7;
		if (optStandard) begin
			next_unitAddr = addrSync2;
		end
	end

	// ********************************
	// bus answer
	// ********************************
	reg next_waitRequest;
	reg [31:0] next_readData;

	// waitrequest low for one cycle per access
	always @* begin
		next_waitRequest = 1'b1;
		if (busStart) begin
			next_waitRequest = 1'b0;
		end
	end

	// read data stands while waitrequest is low
	always @* begin
		next_readData = 32'h0;
		if (avsRead && busStart) begin
			if (ctrlSelect) begin
				next_readData = {29'h0, ctrl};
			end else if (statSelect) begin
				next_readData = {26'h0, PIN_OPTION, 2'h0, lineLevel, muteActive};
			end
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			avsWaitRequest <= 1'b1;
			avsReadData <= 32'h0;
		end else if (clkEn) begin
			avsWaitRequest <= next_waitRequest;
			avsReadData <= next_readData;
		end
	end

	// ********************************
	// amplifier outputs
	// ********************************
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			muteActive <= 1'b1;
			powerStageOn <= 1'b0;
		end else if (clkEn) begin
			muteActive <= next_mute;
			powerStageOn <= ~next_mute;
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			muteBiasPullUp <= 1'b0;
		end else if (clkEn) begin
			muteBiasPullUp <= biasUp;
		end
	end

	// ********************************
	// shared pin outputs
	// ********************************
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			unitAddr <= 3'h7;
		end else if (clkEn) begin
			unitAddr <= next_unitAddr;
		end
	end

	// option is a build-time constant only
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ethSelect <= 1'b0;
			serialSelect <= 1'b0;
		end else if (clkEn) begin
			ethSelect <= optWeb;
			serialSelect <= optSerial;
		end
	end

endmodule // amc_mute_ctrl

// *** test/amc_mute_checker.sv ***
// mute control checker
`timescale 1ns/10ps
module amc_mute_checker(
	input wire clk_sys,
	input wire nrst,
	input wire clkEn,
	input wire avsRead,
	input wire avsWrite,
	input wire [31:0] avsReadData,
	input wire avsWaitRequest,
	input wire muteActive,
	input wire powerStageOn,
	input wire ethSelect,
	input wire serialSelect
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!nrst);
property p_pwr; muteActive |-> !powerStageOn; endproperty
a_pwr: assert property (p_pwr) else $error("stage on");
property p_pwrOn; !muteActive |-> powerStageOn; endproperty
a_pwrOn: assert property (p_pwrOn) else $error("stage off");
property p_opt; !ethSelect && !serialSelect; endproperty
a_opt: assert property (p_opt) else $error("option");
property p_optOne; !(ethSelect && serialSelect); endproperty
a_optOne: assert property (p_optOne) else $error("two options");
property p_wrqOne; (!avsWaitRequest && clkEn) |=> avsWaitRequest; endproperty
a_wrqOne: assert property (p_wrqOne) else $error("long answer");
property p_idle; (!avsRead && !avsWrite && clkEn) |=> avsWaitRequest; endproperty
a_idle: assert property (p_idle) else $error("idle answer");
property p_rdZero; avsWaitRequest |-> (avsReadData == 32'h0); endproperty
a_rdZero: assert property (p_rdZero) else $error("stray data");
endmodule // amc_mute_checker
bind amc_mute_ctrl amc_mute_checker checkInst(.clk_sys(clk_sys), .nrst(nrst),
	.clkEn(clkEn), .avsRead(avsRead), .avsWrite(avsWrite),
	.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
	.muteActive(muteActive), .powerStageOn(powerStageOn),
	.ethSelect(ethSelect), .serialSelect(serialSelect));

// *** test/amc_line_model.sv ***
// external mute line controller
`timescale 1ns/10ps
module amc_line_model(
	input wire drv,
	input wire lvl,
	input wire pullUp,
	output wire line,
	output wire lineDrv
);
assign lineDrv = drv;
assign line = drv ? lvl : pullUp;
endmodule // amc_line_model

// *** test/tb_top.sv ***
// bench for the mute control block
`timescale 1ns/10ps
module tb_top;
// ********************************
// signals
// ********************************
reg clk_sys = 1'b0;
reg nrst = 1'b0;
reg clkEn = 1'b1;
reg rd = 1'b0;
reg wr = 1'b0;
reg drv = 1'b0;
reg lvl = 1'b0;
reg expMute = 1'b0;
reg [3:0] ad = 4'h0;
reg [3:0] be = 4'hF;
reg [31:0] wd = 32'h0;
reg [31:0] got = 32'h0;
wire [31:0] rdd;
wire wrq;
wire pu;
wire pwr;
wire mute;
wire ln;
wire lnd;
wire eth;
wire ser;
wire [2:0] ua;
integer failures = 0;
integer checks = 0;
integer c;
integer k;
always #5 clk_sys = ~clk_sys;
// ********************************
// block and far side
// ********************************
amc_line_model peer(.drv(drv), .lvl(lvl), .pullUp(pu), .line(ln), .lineDrv(lnd));
amc_mute_ctrl dut(.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .avsAddress(ad),
	.avsRead(rd), .avsWrite(wr), .avsWriteData(wd), .avsByteEnable(be),
	.avsReadData(rdd), .avsWaitRequest(wrq), .muteLineIn(ln), .muteLineDriven(lnd),
	.muteBiasPullUp(pu), .powerStageOn(pwr), .muteActive(mute), .unitAddrPinIn0(1'b1),
	.unitAddrPinIn1(1'b0), .unitAddrPinIn2(1'b1), .unitAddr(ua), .ethSelect(eth),
	.serialSelect(ser));
// ********************************
// tasks
// ********************************
task chk(input [31:0] s, input [31:0] e);
	checks = checks + 1;
	if (s !== e) begin
		failures = failures + 1;
		$display("wrong value at %0t: saw %h expected %h", $time, s, e);
	end
endtask
task acc(input w, input [3:0] a, input [31:0] d);
	@(posedge clk_sys);
	ad <= a;
	wd <= d;
	wr <= w;
	rd <= !w;
	@(posedge clk_sys);
	while (wrq !== 1'b0) begin
		@(posedge clk_sys);
	end
	got = rdd;
	wr <= 1'b0;
	rd <= 1'b0;
endtask
task complete_run;
	$display("failures %0d checks %0d", failures, checks);
	if (failures == 0 && checks > 0) begin
		$display("TEST PASSED");
	end else begin
		$display("TEST FAILED");
	end
	$finish;
endtask
// ********************************
// watchdog and tests
// ********************************
initial begin
	#20000;
	failures = failures + 1;
	complete_run;
end
initial begin
	repeat (5) @(posedge clk_sys);
	nrst <= 1'b1;
	acc(0, 4'h0, 32'h0);
	chk(got, 32'h2);
	acc(0, 4'h8, 32'h0);
	chk(got, 32'h0);
	chk(ua, 3'h5);
	chk(eth, 1'b0);
	chk(ser, 1'b0);
	chk(pu, 1'b0);
	drv <= 1'b1;
	lvl <= 1'b1;
	repeat (5) @(posedge clk_sys);
	acc(0, 4'h4, 32'h0);
	chk(got, 32'h3);
	be <= 4'h0;
	acc(1, 4'h0, 32'h1);
	be <= 4'hF;
	acc(0, 4'h0, 32'h0);
	chk(got, 32'h2);
	for (c = 0; c < 4; c = c + 1) begin
		acc(1, 4'h0, c * 2);
		for (k = 0; k < 3; k = k + 1) begin
			@(posedge clk_sys);
			drv <= (k < 2);
			lvl <= k % 2;
			expMute = ((k < 2) ? (k % 2) : (c / 2)) == (c % 2);
			repeat (5) @(posedge clk_sys);
			chk(mute, expMute);
			chk(pwr, !expMute);
			chk(pu, c / 2);
		end
		acc(1, 4'h0, c * 2 + 1);
		repeat (3) @(posedge clk_sys);
		chk(mute, 1'b1);
		chk(pwr, 1'b0);
	end
	acc(1, 4'h0, 32'h2);
	drv <= 1'b1;
	lvl <= 1'b0;
	repeat (5) @(posedge clk_sys);
	chk(mute, 1'b0);
	clkEn <= 1'b0;
	lvl <= 1'b1;
	repeat (5) @(posedge clk_sys);
	chk(mute, 1'b0);
	clkEn <= 1'b1;
	repeat (5) @(posedge clk_sys);
	chk(mute, 1'b1);
	complete_run;
end
endmodule // tb_top
